// ### bench/bsl_props.sv
/* Port checker for the strap latch.
   Assumes a bind into every bsl_boot_strap_latch. */
`timescale 1ns/1ps
`default_nettype none
module bsl_props #(parameter STRAP_W = 16, parameter SETTLE_CYC = 20) (
    input wire logic               ref_clk_i,
    input wire logic               rst_i,
    input wire logic               cold_reset_input_n_i,
    input wire logic [STRAP_W-1:0] strap_pin_i,
    input wire logic               primary_boot_fail_i,
    input wire logic               boot_done_i,
    input wire logic               power_on_reset_indication_out_n_o,
    input wire logic               strap_func_en_o,
    input wire logic [2:0]         pll_ref_sel_o,
    input wire logic [3:0]         pri_boot_src_o,
    input wire logic [2:0]         pri_boot_opt_o,
    input wire logic [2:0]         bkp_boot_src_o,
    input wire logic               bkp_boot_opt_o,
    input wire logic [1:0]         rsvd_strap_o,
    input wire logic               boot_use_backup_o,
    input wire logic               straps_valid_o
);
    wire [15:0] f = {rsvd_strap_o, bkp_boot_opt_o, bkp_boot_src_o, pri_boot_opt_o,
                     pri_boot_src_o, pll_ref_sel_o};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_quiet; $stable(strap_pin_i)[*4]; endsequence
    sequence s_fail; primary_boot_fail_i && straps_valid_o && !boot_done_i; endsequence
    property p_track; s_quiet ##0 !straps_valid_o |-> f == strap_pin_i; endproperty
    property p_hold; straps_valid_o && $past(straps_valid_o) |-> $stable(f); endproperty
    property p_cap; !cold_reset_input_n_i[*4] |-> !power_on_reset_indication_out_n_o; endproperty
    property p_same; power_on_reset_indication_out_n_o == straps_valid_o; endproperty
    property p_func; strap_func_en_o == straps_valid_o; endproperty
    property p_fb; s_fail |=> boot_use_backup_o; endproperty
    property p_only; $rose(boot_use_backup_o) |-> $past(primary_boot_fail_i); endproperty
    property p_done; boot_done_i && !boot_use_backup_o |=> !boot_use_backup_o; endproperty
    a_track: assert property (p_track) else $error("fields differ from straps");
    a_hold: assert property (p_hold) else $error("fields moved after capture");
    a_cap: assert property (p_cap) else $error("no reset indication");
    a_same: assert property (p_same) else $error("valid and indication differ");
    a_func: assert property (p_func) else $error("pin role switch wrong");
    a_fb: assert property (p_fb) else $error("no fallback to backup");
    a_only: assert property (p_only) else $error("backup without failure");
    a_done: assert property (p_done) else $error("fallback after boot done");
endmodule
bind bsl_boot_strap_latch bsl_props #(.STRAP_W(STRAP_W), .SETTLE_CYC(SETTLE_CYC)) chk_u (.*);
`default_nettype wire

// ### bench/bsl_strap_net.sv
/* Board strap network model.
   Assumes hold_n_i is the reset indication of the latch. */
`timescale 1ns/1ps
`default_nettype none
module bsl_strap_net (
    input  wire logic        ref_clk_i,
    input  wire logic        hold_n_i,
    input  wire logic [15:0] cfg_i,
    input  wire logic [15:0] alt_i,
    output var  logic [15:0] strap_o
);
    initial strap_o = 16'h0000;
    // Every bit pulled to a level, reserved ones too
    always @(negedge ref_clk_i)
        strap_o <= hold_n_i ? alt_i : cfg_i;
endmodule
`default_nettype wire

// ### bench/tb.sv
/* Self-checking bench for the strap latch.
   Assumes the checker is bound into the latch. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        ref_clk_i = 0;
    logic        rst_i     = 1;
    logic        cold_n    = 0;
    logic        fail      = 0;
    logic        done      = 0;
    logic [15:0] cfg       = 16'h0000;
    logic [15:0] alt       = 16'h0000;
    logic        v_q       = 0;
    logic        b_q       = 0;
    logic        fl_q      = 0;
    logic [1:0]  e2;
    logic [15:0] fq[$];
    logic [1:0]  bq[$];
    integer      seed      = 72;
    integer      err_total = 0;
    integer      tests_run = 0;
    integer      k;
    wire  [15:0] strap;
    wire  [2:0]  pll, popt, bsrc;
    wire  [3:0]  psrc;
    wire  [1:0]  rsv;
    wire         por_n, func, bopt, bkp, valid, bfail;
    wire  [15:0] f = {rsv, bopt, bsrc, popt, psrc, pll};

    bsl_strap_net net_u (.ref_clk_i(ref_clk_i), .hold_n_i(por_n), .cfg_i(cfg), .alt_i(alt),
        .strap_o(strap));
    bsl_boot_strap_latch #(.STRAP_W(16), .SETTLE_CYC(4)) dut_u (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .cold_reset_input_n_i(cold_n), .strap_pin_i(strap),
        .primary_boot_fail_i(fail), .boot_done_i(done),
        .power_on_reset_indication_out_n_o(por_n), .strap_func_en_o(func),
        .pll_ref_sel_o(pll), .pri_boot_src_o(psrc), .pri_boot_opt_o(popt),
        .bkp_boot_src_o(bsrc), .bkp_boot_opt_o(bopt), .rsvd_strap_o(rsv),
        .boot_use_backup_o(bkp), .boot_failed_o(bfail), .straps_valid_o(valid));

    task cmp_fields(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin err_total++; $display("BAD t=%0t exp=%h got=%h", $time, e, g); end
    endtask
    task cmp_flag(input logic e, input logic g);
        tests_run++;
        if (g !== e) begin err_total++; $display("BAD t=%0t exp=%h got=%h", $time, e, g); end
    endtask
    task summarize;
        if (fq.size() != 0 || bq.size() != 0) err_total++;
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One cold boot, then a primary failure
    task run(input logic d);
        cfg = $random(seed); done = d; cold_n = 0; fail = 0;
        fq.push_back(cfg);
        if (!d) fq.push_back(cfg);
        bq.push_back({!d, !d});
        repeat (6) @(negedge ref_clk_i);
        cold_n = 1;
        k = 0;
        while (valid !== 1'b1 && k < 40) begin @(negedge ref_clk_i); k++; end
        repeat (8) @(negedge ref_clk_i);
        fail = 1;
        repeat (4) @(negedge ref_clk_i);
        fail = 0;
    endtask

    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    always @(negedge ref_clk_i) alt <= $random(seed);
    // ==== Watcher
    always @(posedge ref_clk_i) begin
        #1;
        if (valid === 1'b1 && !v_q) cmp_fields(fq.pop_front(), f);
        if (bkp === 1'b1 && !b_q) cmp_fields(fq.pop_front(), f);
        if (valid !== 1'b1 && v_q) begin
            e2 = bq.pop_front();
            cmp_flag(e2[1], b_q);
            cmp_flag(e2[0], fl_q);
        end
        fl_q = (valid === 1'b1) && (fl_q || bfail === 1'b1);
        v_q = (valid === 1'b1);
        b_q = (bkp === 1'b1);
    end
    initial begin
        repeat (4) @(negedge ref_clk_i);
        rst_i = 0;
        for (int r = 0; r < 4; r++) run(r == 2);
        cold_n = 0;
        repeat (6) @(negedge ref_clk_i);
        summarize;
    end
    initial begin #20000; err_total++; summarize; end
endmodule
`default_nettype wire

// ### rtl/bsl_boot_strap_latch.v
/*
 * Boot strap latch: samples sixteen strap pins while power-on reset is
 * held, freezes them SETTLE_CYC cycles after release, decodes the boot fields, hands the pins
 * to their functional roles and steers primary/backup boot selection.
 * Assumes the cold reset and strap pins are asynchronous to ref_clk_i and
 * that the board holds the straps stable before cold reset is released.
 */
// What this block does
// - Capture all strap levels during power-on reset; indicate capture on reset output.
// - Strap bits 2..0 give reference oscillator frequency for PLL setup.
// - Strap bits 6..3 select the primary boot source.
// - Strap bits 9..7 give primary boot source options.
// - Strap bits 12..10 select backup source, used only after primary fails.
// - Strap bit 13 gives an extra backup boot source option.
// - On primary boot failure while boot_done_i is low, continue by trying the backup source.
// - After capture, strap pins switch to their alternate functions.
`timescale 1ns/1ps
`default_nettype none
`include "bsl_consts.vh"

module bsl_boot_strap_latch #(
    parameter STRAP_W    = `BSL_STRAP_W,
    parameter SETTLE_CYC = `BSL_SETTLE_CYC
) (
    input  wire               ref_clk_i,
    input  wire               rst_i,
    input  wire               cold_reset_input_n_i,
    input  wire [STRAP_W-1:0] strap_pin_i,
    input  wire               primary_boot_fail_i,
    input  wire               boot_done_i,
    output reg                power_on_reset_indication_out_n_o,
    output reg                strap_func_en_o,
    output reg  [2:0]         pll_ref_sel_o,
    output reg  [3:0]         pri_boot_src_o,
    output reg  [2:0]         pri_boot_opt_o,
    output reg  [2:0]         bkp_boot_src_o,
    output reg                bkp_boot_opt_o,
    output reg  [1:0]         rsvd_strap_o,
    output reg                boot_use_backup_o,
    output reg                boot_failed_o,
    output reg                straps_valid_o
);
    // =====================================================================
    // Synchronisers
    // =====================================================================
    wire [STRAP_W-1:0] strap_sync;
    wire [0:0]         cold_rel_sync;
    wire [0:0]         por_sync;

    bsl_sync #(.W(STRAP_W)) u_strap_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .d_i       (strap_pin_i),
        .q_o       (strap_sync)
    );

    bsl_sync #(.W(1)) u_por_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .d_i       (cold_reset_input_n_i),
        .q_o       (cold_rel_sync)
    );

    // Sync clears to the held side: capture in force out of reset
    assign por_sync = ~cold_rel_sync;

    // =====================================================================
    // Field extraction
    // =====================================================================
    function [3:0] field;
        input [STRAP_W-1:0] v;
        input integer       lsb;
        input integer       w;
        integer             k;
        begin
            field = 4'h0;
            for (k = 0; k < w; k = k + 1)
                field[k] = v[lsb + k];
        end
    endfunction

    // =====================================================================
    // Sequencer
    // =====================================================================
    localparam [1:0] ST_CAPTURE = 2'b00;
    localparam [1:0] ST_SETTLE  = 2'b01;
    localparam [1:0] ST_PRIMARY = 2'b10;
    localparam [1:0] ST_BACKUP  = 2'b11;

    function in_capture;
        input [1:0] s;
        begin
            in_capture = (s == ST_CAPTURE) || (s == ST_SETTLE);
        end
    endfunction

    localparam CNT_W = 16;

    reg [1:0]         state_ff;
    reg [1:0]         nxt_state;
    reg [CNT_W-1:0]   cnt_ff;
    reg [CNT_W-1:0]   nxt_cnt;
    reg [STRAP_W-1:0] strap_ff;

    always @*
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_CAPTURE:
            begin
                nxt_cnt = {CNT_W{1'b0}};
                if (!por_sync[0])
                    nxt_state = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                // Keep straps sampled a little past release
                if (por_sync[0])
                    nxt_state = ST_CAPTURE;
                else if (cnt_ff == SETTLE_CYC[CNT_W-1:0] - 16'h0001)
                    nxt_state = ST_PRIMARY;
                else
                    nxt_cnt = cnt_ff + 16'h0001;
            end
            ST_PRIMARY:
            begin
                if (por_sync[0])
                    nxt_state = ST_CAPTURE;
                // Fallback refused once boot is done
                else if (primary_boot_fail_i && !boot_done_i)
                    nxt_state = ST_BACKUP;
            end
            ST_BACKUP:
            begin
                // Terminal until the next cold reset
                if (por_sync[0])
                    nxt_state = ST_CAPTURE;
            end
            default:
                nxt_state = ST_CAPTURE;
        endcase
    end

    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= ST_CAPTURE;
            cnt_ff   <= {CNT_W{1'b0}};
            strap_ff <= `BSL_STRAP_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            if (in_capture(state_ff))
                strap_ff <= strap_sync;
            // Frozen otherwise until next power-on reset
        end
    end

    // =====================================================================
    // Registered outputs
    // =====================================================================
    wire running = (nxt_state == ST_PRIMARY) || (nxt_state == ST_BACKUP);
    wire [STRAP_W-1:0] nxt_strap = in_capture(state_ff) ? strap_sync : strap_ff;

    // Four-bit results, cut to each field width
    wire [3:0] pll_fld     = field(nxt_strap, `BSL_PLL_LSB, `BSL_PLL_W);
    wire [3:0] pri_src_fld = field(nxt_strap, `BSL_PRI_SRC_LSB, `BSL_PRI_SRC_W);
    wire [3:0] pri_opt_fld = field(nxt_strap, `BSL_PRI_OPT_LSB, `BSL_PRI_OPT_W);
    wire [3:0] bkp_src_fld = field(nxt_strap, `BSL_BKP_SRC_LSB, `BSL_BKP_SRC_W);
    wire [3:0] rsvd_fld    = field(nxt_strap, `BSL_RSVD_LSB, `BSL_RSVD_W);

    // Status flags
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            power_on_reset_indication_out_n_o <= 1'b0;
            strap_func_en_o                   <= 1'b0;
            boot_use_backup_o                 <= 1'b0;
            boot_failed_o                     <= 1'b0;
            straps_valid_o                    <= 1'b0;
        end
        else
        begin
            power_on_reset_indication_out_n_o <= running;
            strap_func_en_o                   <= running;
            straps_valid_o                    <= running;
            boot_use_backup_o <= (nxt_state == ST_BACKUP);
            boot_failed_o     <= (state_ff == ST_BACKUP) && primary_boot_fail_i
                                 && (nxt_state == ST_BACKUP);
        end
    end

    // Decoded strap fields
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pll_ref_sel_o  <= 3'h0;
            pri_boot_src_o <= 4'h0;
            pri_boot_opt_o <= 3'h0;
            bkp_boot_src_o <= 3'h0;
            bkp_boot_opt_o <= 1'b0;
            rsvd_strap_o   <= 2'h0;
        end
        else
        begin
            pll_ref_sel_o  <= pll_fld[2:0];
            pri_boot_src_o <= pri_src_fld;
            pri_boot_opt_o <= pri_opt_fld[2:0];
            bkp_boot_src_o <= bkp_src_fld[2:0];
            bkp_boot_opt_o <= nxt_strap[`BSL_BKP_OPT_BIT];
            rsvd_strap_o   <= rsvd_fld[1:0];
        end
    end
endmodule

`default_nettype wire

// ### rtl/bsl_consts.vh
/*
 * Constants for the boot strap latch: strap field positions, widths,
 * reset values and the settle time for the cold reset release.
 * Assumes inclusion by the design files only; definitions only.
 */
`ifndef BSL_CONSTS_VH
`define BSL_CONSTS_VH

`define BSL_STRAP_W         16
`define BSL_PLL_LSB         0
`define BSL_PLL_W           3
`define BSL_PRI_SRC_LSB     3
`define BSL_PRI_SRC_W       4
`define BSL_PRI_OPT_LSB     7
`define BSL_PRI_OPT_W       3
`define BSL_BKP_SRC_LSB     10
`define BSL_BKP_SRC_W       3
`define BSL_BKP_OPT_BIT     13
`define BSL_RSVD_LSB        14
`define BSL_RSVD_W          2
`define BSL_STRAP_RST       16'h0000
`define BSL_CLK_MHZ         200
`define BSL_SETTLE_NS       100
`define BSL_SETTLE_CYC      ((`BSL_SETTLE_NS * `BSL_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/bsl_sync.v
/*
 * Two-stage synchroniser for a bus of asynchronous levels.
 * Assumes each bit is a slow, quasi-static level.
 */
`timescale 1ns/1ps
`default_nettype none

module bsl_sync #(
    parameter W = 16
) (
    input  wire         ref_clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end
        else
        begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule

`default_nettype wire
